/* File: hdl/sse_pkg.sv */
// Purpose: Shared types and constants for the shift, skip and parameter-flag slice.
// Assumes: 16-bit instruction words, 7-bit data memory addresses, 11-bit program counter.
// Notes:   Avalon-MM word registers sit at byte offsets that are multiples of four.
package sse_pkg;

    // ------------------------------------------------------------------
    // Opcode prefixes
    // ------------------------------------------------------------------
    localparam logic [8:0]  OP_SHIFT_LEFT  = 9'h098;    // Bits 15..7
    localparam logic [8:0]  OP_SHIFT_RIGHT = 9'h09a;    // Bits 15..7
    localparam logic [8:0]  OP_SKIP_BIT0   = 9'h110;    // Bits 15..7
    localparam logic [8:0]  OP_SKIP_BIT1   = 9'h111;    // Bits 15..7
    localparam logic [8:0]  OP_SKIP_BIT2   = 9'h114;    // Bits 15..7
    localparam logic [11:0] OP_PARAM_FLAGS = 12'h0b0;   // Bits 15..4
    localparam int          PFLAG_WDT_SEL  = 3;         // Watchdog clock select bit

    // ------------------------------------------------------------------
    // Widths, divider counts and reset values
    // ------------------------------------------------------------------
    localparam int          PC_W          = 11;
    localparam int          DIV_W         = 15;
    localparam int          WDT_DIV_LONG  = 16384;      // Fosc/16384
    localparam int          WDT_DIV_SHORT = 1024;       // Plain default
    localparam logic [10:0] PC_RST        = 11'h000;
    localparam logic [3:0]  PFLAG_RST     = 4'h0;
    localparam logic        RUN_RST       = 1'b1;

    // ------------------------------------------------------------------
    // Register map (byte addresses) and status field positions
    // ------------------------------------------------------------------
    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_STATUS = 4'h4;
    localparam int          ST_PC_LSB  = 0;
    localparam int          ST_ACC_LSB = 11;
    localparam int          ST_CARRY   = 15;
    localparam int          ST_ZERO    = 16;
    localparam int          ST_PF_LSB  = 17;
    localparam int          ST_BUSY    = 21;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } exec_state_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } av_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } av_rsp_s;

    typedef struct packed {
        logic [6:0] addr;
        logic [3:0] wdata;
        logic       we;
    } mem_port_s;

    typedef struct packed {
        exec_state_e st;
        logic [15:0] instr;
        logic [10:0] pc;
        logic [3:0]  accumulator;
        logic        carry_flag;
        logic        zero_flag;
        logic [3:0]  pflags;
        logic        run;
        logic        ready;
        logic        done;
        mem_port_s   mem;
        av_rsp_s     av;
    } core_state_s;

    localparam core_state_s CORE_RST = '{
        st:          ST_IDLE,
        instr:       16'h0000,
        pc:          PC_RST,
        accumulator: 4'h0,
        carry_flag:  1'b0,
        zero_flag:   1'b0,
        pflags:      PFLAG_RST,
        run:         RUN_RST,
        ready:       RUN_RST,
        done:        1'b0,
        mem:         '{addr: 7'h00, wdata: 4'h0, we: 1'b0},
        av:          '{readdata: 32'h0000_0000, waitrequest: 1'b1}
    };

endpackage

/* File: hdl/wdt_prescaler.sv */
// Purpose: Divides the core clock into a one-cycle watchdog tick enable.
// Assumes: Divisors are at least 2 and fit in the counter.
// Notes:   Changing the select restarts the count so no short tick appears.
`timescale 1ns/1ps
module wdt_prescaler #(
    parameter int DIV_LONG  = sse_pkg::WDT_DIV_LONG,   // Divisor when select high
    parameter int DIV_SHORT = sse_pkg::WDT_DIV_SHORT   // Divisor when select low
) (
    input  wire logic i_clk,       // Core clock
    input  wire logic i_srst,      // Synchronous reset, active high
    input  wire logic i_sel_long,  // Select long divisor
    output logic      o_tick       // One-cycle watchdog clock enable
);

    typedef struct packed {
        logic [sse_pkg::DIV_W-1:0] cnt;
        logic                      sel;
        logic                      tick;
    } div_state_s;

    div_state_s s_ff;
    div_state_s nxt_s;
    logic [sse_pkg::DIV_W-1:0] last;

    // Terminal count for the selected divisor
    assign last = s_ff.sel ? sse_pkg::DIV_W'(DIV_LONG - 1) : sse_pkg::DIV_W'(DIV_SHORT - 1);

    // Count and emit the tick on terminal count
    always_comb begin
        nxt_s      = s_ff;
        nxt_s.sel  = i_sel_long;
        nxt_s.tick = 1'b0;
        if (s_ff.sel != i_sel_long) begin
            nxt_s.cnt = '0;
        end else if (s_ff.cnt == last) begin
            nxt_s.cnt  = '0;
            nxt_s.tick = 1'b1;
        end else begin
            nxt_s.cnt = s_ff.cnt + sse_pkg::DIV_W'(1);
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign o_tick = s_ff.tick;

endmodule

/* File: hdl/shift_skip_param_exec.sv */
// Purpose: Decodes and executes parameter-flag write, shifts via carry and bit-skip.
// Assumes: Data memory returns the nibble at o_mem.addr in the same clock that it is driven.
// Notes:   One machine cycle is two clocks: latch and address, then execute.
//
// Summary of operation
// RL1: Flag bit 3 set selects watchdog clock Fosc/16384
// RL2: Flag bits 0 to 2 are reserved
// RL3: Decode left shift prefix, one machine cycle
// RL4: Left shift: bit3 to carry, zero in
// RL5: Decode right shift prefix, one machine cycle
// RL6: Right shift: bit0 to carry, zero in
// RL7: Bit 0 set skips, PC plus two
// RL8: Bit 1 set skips, PC plus two
// RL9: Bit 2 set skips, PC plus two
// RL10: Program counter is eleven bits, wraps
// RL11: Shifts set zero flag; skips keep flags
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
module shift_skip_param_exec #(
    parameter int WDT_DIV_LONG  = sse_pkg::WDT_DIV_LONG,   // Long watchdog divisor
    parameter int WDT_DIV_SHORT = sse_pkg::WDT_DIV_SHORT   // Short watchdog divisor
) (
    input  wire logic               i_clk,          // Core clock, 250 MHz
    input  wire logic               i_srst,         // Synchronous reset, active high
    input  wire logic [15:0]        i_instr,        // Instruction word at o_pc
    input  wire logic               i_instr_valid,  // Instruction word present
    input  wire logic [3:0]         i_mem_rdata,    // Nibble at o_mem.addr
    input  wire sse_pkg::av_req_s   i_av,           // Avalon-MM request
    output sse_pkg::av_rsp_s        o_av,           // Avalon-MM response
    output sse_pkg::mem_port_s      o_mem,          // Data memory address and write
    output logic [10:0]             o_pc,           // Program counter
    output logic [3:0]              o_accumulator,  // Accumulator
    output logic                    o_carry_flag,   // Carry flag
    output logic                    o_zero_flag,    // Zero flag
    output logic [3:0]              o_pflags,       // Parameter flag word
    output logic                    o_ready,        // Ready to take an instruction
    output logic                    o_done,         // Instruction finished, one cycle
    output logic                    o_wdt_tick      // Watchdog clock enable pulse
);

    sse_pkg::core_state_s s_ff;
    sse_pkg::core_state_s nxt_s;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Zero test of a four-bit result
    function automatic logic is_zero(input logic [3:0] v);
        is_zero = (v == 4'h0);
    endfunction

    // Next program counter, plus one or plus two, wrapping in eleven bits
    function automatic logic [10:0] pc_step(input logic [10:0] pc, input logic skip);
        pc_step = skip ? pc + 11'h002 : pc + 11'h001; // RL10
    endfunction

    // Status word for the register bus
    function automatic logic [31:0] status_word(input sse_pkg::core_state_s s);
        status_word = 32'h0000_0000;
        status_word[sse_pkg::ST_PC_LSB +: sse_pkg::PC_W] = s.pc;
        status_word[sse_pkg::ST_ACC_LSB +: 4]            = s.accumulator;
        status_word[sse_pkg::ST_CARRY]                   = s.carry_flag;
        status_word[sse_pkg::ST_ZERO]                    = s.zero_flag;
        status_word[sse_pkg::ST_PF_LSB +: 4]             = s.pflags;
        status_word[sse_pkg::ST_BUSY]                    = (s.st == sse_pkg::ST_EXEC);
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    // Bus slave, instruction sequencing and execution
    always_comb begin
        logic [3:0] res;
        logic [8:0] op;
        res          = 4'h0;
        op           = s_ff.instr[15:7];
        nxt_s        = s_ff;
        nxt_s.done   = 1'b0;
        nxt_s.mem.we = 1'b0;

        // Avalon slave: answer one clock after the request is seen
        if ((i_av.read || i_av.write) && s_ff.av.waitrequest) begin
            nxt_s.av.waitrequest = 1'b0;
            if (i_av.read && i_av.address == sse_pkg::REG_CTRL) begin
                nxt_s.av.readdata = {31'h0000_0000, s_ff.run};
            end else if (i_av.read && i_av.address == sse_pkg::REG_STATUS) begin
                nxt_s.av.readdata = status_word(s_ff);
            end else begin
                nxt_s.av.readdata = 32'h0000_0000;
            end
        end else begin
            nxt_s.av.waitrequest = 1'b1;
        end

        // Write takes effect at the edge where waitrequest is seen low
        if (i_av.write && !s_ff.av.waitrequest && i_av.address == sse_pkg::REG_CTRL
                && i_av.byteenable[0]) begin
            nxt_s.run = i_av.writedata[0];
        end

        case (s_ff.st)
            sse_pkg::ST_IDLE: begin
                if (i_instr_valid && s_ff.run) begin
                    nxt_s.instr    = i_instr;
                    nxt_s.mem.addr = i_instr[6:0];
                    nxt_s.st       = sse_pkg::ST_EXEC;
                end
            end
            sse_pkg::ST_EXEC: begin
                nxt_s.st   = sse_pkg::ST_IDLE;
                nxt_s.done = 1'b1;
                nxt_s.pc   = pc_step(s_ff.pc, 1'b0);
                if (s_ff.instr[15:4] == sse_pkg::OP_PARAM_FLAGS) begin
                    nxt_s.pflags = s_ff.instr[3:0]; // RL1 RL2
                end else if (op == sse_pkg::OP_SHIFT_LEFT) begin // RL3
                    res               = {i_mem_rdata[2:0], 1'b0}; // RL4
                    nxt_s.carry_flag  = i_mem_rdata[3]; // RL4
                    nxt_s.zero_flag   = is_zero(res); // RL11
                    nxt_s.accumulator = res;
                    nxt_s.mem.wdata   = res;
                    nxt_s.mem.we      = 1'b1;
                end else if (op == sse_pkg::OP_SHIFT_RIGHT) begin // RL5
                    res               = {1'b0, i_mem_rdata[3:1]}; // RL6
                    nxt_s.carry_flag  = i_mem_rdata[0]; // RL6
                    nxt_s.zero_flag   = is_zero(res); // RL11
                    nxt_s.accumulator = res;
                    nxt_s.mem.wdata   = res;
                    nxt_s.mem.we      = 1'b1;
                end else if (op == sse_pkg::OP_SKIP_BIT0) begin
                    nxt_s.pc = pc_step(s_ff.pc, i_mem_rdata[0]); // RL7
                end else if (op == sse_pkg::OP_SKIP_BIT1) begin
                    nxt_s.pc = pc_step(s_ff.pc, i_mem_rdata[1]); // RL8
                end else if (op == sse_pkg::OP_SKIP_BIT2) begin
                    nxt_s.pc = pc_step(s_ff.pc, i_mem_rdata[2]); // RL9
                end
            end
            default: begin
                nxt_s.st = sse_pkg::ST_IDLE;
            end
        endcase

        nxt_s.ready = (nxt_s.st == sse_pkg::ST_IDLE) && nxt_s.run;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Whole block state in one register
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_ff <= sse_pkg::CORE_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog clock prescaler
    // ------------------------------------------------------------------

    // Flag bit 3 picks the long divisor
    wdt_prescaler #(
        .DIV_LONG  (WDT_DIV_LONG),
        .DIV_SHORT (WDT_DIV_SHORT)
    ) u_wdt_prescaler (
        .i_clk      (i_clk),
        .i_srst     (i_srst),
        .i_sel_long (s_ff.pflags[sse_pkg::PFLAG_WDT_SEL]), // RL1
        .o_tick     (o_wdt_tick)
    );

    // Outputs straight from the state register
    assign o_av          = s_ff.av;
    assign o_mem         = s_ff.mem;
    assign o_pc          = s_ff.pc;
    assign o_accumulator = s_ff.accumulator;
    assign o_carry_flag  = s_ff.carry_flag;
    assign o_zero_flag   = s_ff.zero_flag;
    assign o_pflags      = s_ff.pflags;
    assign o_ready       = s_ff.ready;
    assign o_done        = s_ff.done;

endmodule

/* File: test/sse_assertions.sv */
// Purpose: Assertions for the shift, skip and flag-write slice.
// Assumes: Done comes two edges after an instruction is taken.
// Notes:   Watchdog gap count restarts on tick or select change.
`timescale 1ns/1ps
module sse_assertions #(
    parameter int WDT_DIV_LONG  = 8, // Long divisor
    parameter int WDT_DIV_SHORT = 4  // Short divisor
) (
    input wire logic               i_clk,         // Clock
    input wire logic               i_srst,        // Reset
    input wire logic [15:0]        i_instr,       // Word
    input wire logic               i_instr_valid, // Word present
    input wire logic [3:0]         i_mem_rdata,   // Nibble
    input wire sse_pkg::mem_port_s o_mem,         // Memory port
    input wire logic [10:0]        o_pc,          // PC
    input wire logic [3:0]         o_accumulator, // Accumulator
    input wire logic               o_carry_flag,  // Carry
    input wire logic               o_zero_flag,   // Zero
    input wire logic [3:0]         o_pflags,      // Flags
    input wire logic               o_ready,       // Ready
    input wire logic               o_done,        // Done
    input wire logic               o_wdt_tick     // Tick
);
    logic [15:0] ins_ff, cnt_ff;
    logic        sel_ff, clean_ff, chg, hit;
    int          div;
    // Word in execute, last select, watchdog gap count
    always_ff @(posedge i_clk) begin
        ins_ff   <= i_instr;
        sel_ff   <= o_pflags[3];
        cnt_ff   <= (i_srst || o_wdt_tick || chg) ? 16'h0000 : cnt_ff + 16'h0001;
        clean_ff <= !i_srst && !chg && (o_wdt_tick || clean_ff);
    end
    // Select change and skip condition
    assign chg = o_pflags[3] != sel_ff;
    assign div = o_pflags[3] ? WDT_DIV_LONG : WDT_DIV_SHORT;
    assign hit = ins_ff[15:7] inside {sse_pkg::OP_SKIP_BIT0, sse_pkg::OP_SKIP_BIT1,
                 sse_pkg::OP_SKIP_BIT2} && i_mem_rdata[{ins_ff[9], ins_ff[7]}];
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    shl_result_a: assert property (o_done && $past(i_instr[15:7], 2) == 9'h098 |->
        o_accumulator == {$past(i_mem_rdata[2:0]), 1'b0} && o_carry_flag == $past(i_mem_rdata[3]))
        else $error("left shift wrong");
    shr_result_a: assert property (o_done && $past(i_instr[15:7], 2) == 9'h09a |->
        o_accumulator == {1'b0, $past(i_mem_rdata[3:1])} && o_carry_flag == $past(i_mem_rdata[0]))
        else $error("right shift wrong");
    shift_store_a: assert property (o_done && $past(i_instr[15:7], 2) inside {9'h098, 9'h09a} |->
        o_mem.we && o_mem.wdata == o_accumulator && o_zero_flag == (o_accumulator == 4'h0))
        else $error("shift store or zero wrong");
    skip_keep_a: assert property (o_done && $past(i_instr[15:11], 2) == 5'h11 |->
        $stable(o_accumulator) && $stable(o_carry_flag) && $stable(o_zero_flag) && !o_mem.we)
        else $error("skip touched flags");
    pc_step_a: assert property (
        o_done |-> o_pc == $past(o_pc) + ($past(hit) ? 11'h002 : 11'h001)) else $error("pc step");
    pflag_write_a: assert property (o_done && $past(i_instr[15:4], 2) == 12'h0b0 |->
        o_pflags == $past(i_instr[3:0], 2)) else $error("flag word wrong");
    one_cycle_a: assert property (
        o_ready && i_instr_valid |=> !o_ready ##1 o_done) else $error("machine cycle length");
    wdt_period_a: assert property (
        o_wdt_tick && clean_ff && !chg |-> cnt_ff == 16'(div - 1)) else $error("tick period");
    wdt_bound_a: assert property (
        !chg |-> cnt_ff <= 16'(div + 1)) else $error("tick missing");
endmodule
bind shift_skip_param_exec sse_assertions #(.WDT_DIV_LONG(WDT_DIV_LONG),
    .WDT_DIV_SHORT(WDT_DIV_SHORT)) u_sse_assertions (.i_clk(i_clk), .i_srst(i_srst),
    .i_instr(i_instr), .i_instr_valid(i_instr_valid), .i_mem_rdata(i_mem_rdata), .o_mem(o_mem),
    .o_pc(o_pc), .o_accumulator(o_accumulator), .o_carry_flag(o_carry_flag),
    .o_zero_flag(o_zero_flag), .o_pflags(o_pflags), .o_ready(o_ready), .o_done(o_done),
    .o_wdt_tick(o_wdt_tick));

/* File: test/mem_model.sv */
// Purpose: Program and data memory beside the core.
// Assumes: Nibble read is combinational on the address.
// Notes:   Word is inverted while no fetch is offered.
`timescale 1ns/1ps
module mem_model (
    input  wire logic               i_clk,   // Clock
    input  wire logic [10:0]        i_pc,    // Fetch address
    input  wire logic               i_valid, // Fetch offered
    input  wire sse_pkg::mem_port_s i_mem,   // Data port
    output logic [15:0]             o_instr, // Word
    output logic [3:0]              o_rdata  // Nibble
);
    logic [15:0] rom [2048];
    logic [3:0]  ram [128];
    // Fetch and read paths
    assign o_instr = i_valid ? rom[i_pc] : ~rom[i_pc];
    assign o_rdata = ram[i_mem.addr];
    // Shift result write back
    always @(posedge i_clk) begin
        if (i_mem.we)
            ram[i_mem.addr] <= i_mem.wdata;
    end
endmodule

/* File: test/testbench.sv */
// Purpose: Self-checking bench for the shift, skip and flag-write slice.
// Assumes: Watchdog divisors cut to 8 and 4.
// Notes:   Expected results are queued up front and matched on done.
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [10:0] pc;
        logic [3:0]  acc;
        logic [1:0]  cz;
        logic [3:0]  pf;
        logic        we;
        logic [3:0]  wd;
    } exp_s;
    logic               i_clk, i_srst, i_instr_valid, go, o_ready, o_done;
    logic [15:0]        i_instr, w;
    logic [10:0]        o_pc, epc;
    logic [3:0]         i_mem_rdata, o_acc, o_pf, eacc, epf, d, n;
    logic [3:0]         eram [128];
    logic [31:0]        q, r, seed;
    logic [1:0]         fl, ecz;
    sse_pkg::av_req_s   av;
    sse_pkg::av_rsp_s   o_av;
    sse_pkg::mem_port_s o_mem;
    exp_s               exq [$];
    exp_s               e;
    int                 fail_count, n_tests, taken, cyc;
    shift_skip_param_exec #(.WDT_DIV_LONG(8), .WDT_DIV_SHORT(4)) u_shift_skip_param_exec (
        .i_clk(i_clk), .i_srst(i_srst), .i_instr(i_instr), .i_instr_valid(i_instr_valid),
        .i_mem_rdata(i_mem_rdata), .i_av(av), .o_av(o_av), .o_mem(o_mem), .o_pc(o_pc),
        .o_accumulator(o_acc), .o_carry_flag(fl[1]), .o_zero_flag(fl[0]), .o_pflags(o_pf),
        .o_ready(o_ready), .o_done(o_done), .o_wdt_tick());
    mem_model u_mem_model (.i_clk(i_clk), .i_pc(o_pc), .i_valid(i_instr_valid), .i_mem(o_mem),
        .o_instr(i_instr), .o_rdata(i_mem_rdata));
    // Clock
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
        n_tests++;
        if (y !== x) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", s, x, y);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One bus word, held until waitrequest is seen low
    task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clk);
        av <= '{read: !wr, write: wr, address: a, byteenable: 4'hf, writedata: v};
        do @(posedge i_clk); while (o_av.waitrequest !== 1'b0);
        q = o_av.readdata;
        av <= '0;
    endtask
    // Expected outcome of the word at the model pc
    task automatic ref_step();
        w = u_mem_model.rom[epc];
        d = eram[w[6:0]];
        n = w[15:7] == sse_pkg::OP_SHIFT_LEFT ? {d[2:0], 1'b0} : {1'b0, d[3:1]};
        if (w[15:7] inside {sse_pkg::OP_SHIFT_LEFT, sse_pkg::OP_SHIFT_RIGHT}) begin
            ecz = {w[8] ? d[0] : d[3], n == 4'h0};
            eacc = n;
            eram[w[6:0]] = n;
        end
        if (w[15:4] == sse_pkg::OP_PARAM_FLAGS)
            epf = w[3:0];
        epc = epc + ((w[15:7] inside {sse_pkg::OP_SKIP_BIT0, sse_pkg::OP_SKIP_BIT1,
              sse_pkg::OP_SKIP_BIT2} && d[{w[9], w[7]}]) ? 11'h002 : 11'h001);
        exq.push_back('{epc, eacc, ecz, epf,
                        w[15:7] inside {sse_pkg::OP_SHIFT_LEFT, sse_pkg::OP_SHIFT_RIGHT}, n});
    endtask
    // Match each done against the oldest note
    always @(negedge i_clk) begin
        if (!i_srst && o_done === 1'b1) begin
            e = exq.pop_front();
            chk("pc", e.pc, o_pc);
            chk("acc", e.acc, o_acc);
            chk("carry zero", e.cz, fl);
            chk("pflags", e.pf, o_pf);
            chk("mem we", e.we, o_mem.we);
            chk("mem data", e.we ? e.wd : 4'h0, e.we ? o_mem.wdata : 4'h0);
        end
    end
    // Offer words with random stalls, stop after the program
    always @(posedge i_clk) begin
        r = $random(seed);
        cyc++;
        taken += int'(o_ready === 1'b1 && i_instr_valid);
        i_instr_valid <= go && taken < 2100 && r[1:0] != 2'b00;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        seed = 32'h515b_c0bb;
        {fail_count, n_tests, taken, cyc} = '0;
        {i_srst, i_instr_valid, go, av} = {3'b100, 42'h0};
        {epc, eacc, ecz, epf} = '0;
        for (int i = 0; i < 2048; i++) begin
            r = $random(seed);
            u_mem_model.rom[i] = {9'h1ff, r[6:0]};
            case (r[18:16])
                3'd0: u_mem_model.rom[i][15:7] = sse_pkg::OP_SHIFT_LEFT;
                3'd1: u_mem_model.rom[i][15:7] = sse_pkg::OP_SHIFT_RIGHT;
                3'd2: u_mem_model.rom[i][15:7] = sse_pkg::OP_SKIP_BIT0;
                3'd3: u_mem_model.rom[i][15:7] = sse_pkg::OP_SKIP_BIT1;
                3'd4: u_mem_model.rom[i][15:7] = sse_pkg::OP_SKIP_BIT2;
                3'd5: u_mem_model.rom[i] = {sse_pkg::OP_PARAM_FLAGS, r[3:0]};
                default: ;
            endcase
            u_mem_model.ram[i % 128] = r[22:19];
            eram[i % 128] = r[22:19];
        end
        for (int i = 0; i < 2100; i++)
            ref_step();
        repeat (4) @(posedge i_clk);
        i_srst <= 1'b0;
        av_xfer(0, sse_pkg::REG_CTRL, 0);
        chk("ctrl reset", 1, q);
        av_xfer(0, sse_pkg::REG_STATUS, 0);
        chk("status reset", 0, q);
        av_xfer(0, 4'h8, 0);
        chk("unmapped", 0, q);
        $display("test registers done");
        go <= 1'b1;
        repeat (1500) @(posedge i_clk);
        av_xfer(1, sse_pkg::REG_CTRL, 0);
        repeat (4) @(posedge i_clk);
        av_xfer(0, sse_pkg::REG_STATUS, 0);
        chk("paused status", {11'h0, e.pf, e.cz[0], e.cz[1], e.acc, e.pc}, q);
        av_xfer(1, sse_pkg::REG_CTRL, 1);
        $display("test pause done");
        while (exq.size() != 0)
            @(posedge i_clk);
        $display("test program done");
        tally_and_finish();
    end
endmodule
